// [common/bgc_pkg.sv]
// Purpose: shared constants and types of the bridge general control registers
// Assumes: configuration offsets are byte offsets of aligned dwords
// Notes:   timing counts derive from the time and the system clock rate
package bgc_pkg;

	// configuration offsets
	localparam logic [7:0]  BGC_OFF_SUBSYS_RO = 8'h84; // maker code low, product code at 86h
	localparam logic [7:0]  BGC_OFF_ALIAS     = 8'hd0;
	localparam logic [7:0]  BGC_OFF_CTRL      = 8'hd4;

	// reset values and writable masks
	localparam logic [31:0] BGC_ALIAS_RST     = 32'h00000000;
	localparam logic [31:0] BGC_CTRL_RST      = 32'h8206c000;
	localparam logic [31:0] BGC_CTRL_WMASK    = 32'hcfffffff; // bits 29:28 read zero
	localparam logic [31:0] BGC_RD_UNMAPPED   = 32'h00000000;

	// field positions
	localparam int          BGC_PRODUCT_LSB   = 16;
	localparam int          BGC_RETRY_LSB     = 30;
	localparam int          BGC_RSVD_LSB      = 28;
	localparam int          BGC_LOWSWING_BIT  = 27;
	localparam int          BGC_PMREV_BIT     = 26;
	localparam int          BGC_STRICT_BIT    = 25;
	localparam int          BGC_RDMULT_BIT    = 24;
	localparam int          BGC_ASPM_BIT      = 23;
	localparam int          BGC_PWR_LSB       = 20;

	// encoded values
	localparam logic [2:0]  BGC_PMREV_V11     = 3'h2;
	localparam logic [2:0]  BGC_PMREV_V12     = 3'h3;
	localparam logic [2:0]  BGC_LPC_STRICT    = 3'h0;
	localparam logic [2:0]  BGC_LPC_DEF_CLR   = 3'h1;
	localparam logic [1:0]  BGC_ASPM_OFF      = 2'h0;
	localparam logic [1:0]  BGC_ASPM_L0S_L1   = 2'h3;

	// slot power response codes, 101..111 are reserved
	typedef enum logic [2:0] {
		BGC_PWR_IGNORE  = 3'b000,
		BGC_PWR_PIN     = 3'b001,
		BGC_PWR_CLKSTOP = 3'b010,
		BGC_PWR_BOTH    = 3'b011,
		BGC_PWR_UR      = 3'b100
	} bgc_pwr_resp_t;

	typedef enum logic [0:0] {
		BGC_TMR_IDLE = 1'b0,
		BGC_TMR_RUN  = 1'b1
	} bgc_tmr_state_t;

	// configuration retry times
	localparam int          BGC_CLK_MHZ       = 125;
	localparam int          BGC_RETRY0_US     = 25;
	localparam int          BGC_RETRY1_US     = 1000;
	localparam int          BGC_RETRY2_US     = 25000;
	localparam int          BGC_RETRY3_US     = 50000;
	localparam int          BGC_RETRY0_CYC    = BGC_RETRY0_US * BGC_CLK_MHZ;
	localparam int          BGC_RETRY_CW      = 23;

endpackage

// [design/bgc_retry_timer.sv]
// Purpose: configuration retry timeout on the secondary bus
// Assumes: start and done come from logic on the same clock
// Notes:   expire pulses exactly the selected count of cycles after start
`timescale 1ns/10ps
module bgc_retry_timer
	import bgc_pkg::*;
#(
	parameter int unsigned C1 = BGC_RETRY1_US * BGC_CLK_MHZ,
	parameter int unsigned C2 = BGC_RETRY2_US * BGC_CLK_MHZ,
	parameter int unsigned C3 = BGC_RETRY3_US * BGC_CLK_MHZ
) (
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       start,
	input  wire logic       done,
	input  wire logic [1:0] sel,
	output logic            expire,
	output logic            busy
);

	bgc_tmr_state_t          state_r;
	logic [BGC_RETRY_CW-1:0] cnt_r;
	logic [BGC_RETRY_CW-1:0] lim_r;
	logic [BGC_RETRY_CW-1:0] age_r;

	// select lookup, shared by load and checking
	function automatic logic [BGC_RETRY_CW-1:0] limit(input logic [1:0] s);
		case (s)
			2'h0: limit = BGC_RETRY_CW'(BGC_RETRY0_CYC);
			2'h1: limit = BGC_RETRY_CW'(C1);
			2'h2: limit = BGC_RETRY_CW'(C2);
			default: limit = BGC_RETRY_CW'(C3);
		endcase
	endfunction

	// a fresh start restarts the wait even while one is running
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			state_r <= BGC_TMR_IDLE;
			cnt_r   <= '0;
			lim_r   <= '0;
			age_r   <= '0;
			expire  <= 1'b0;
		end
		else
		begin
			expire <= 1'b0;
			case (state_r)
				BGC_TMR_IDLE:
				begin
					if (start)
					begin
						state_r <= BGC_TMR_RUN;
						cnt_r   <= limit(sel);
						lim_r   <= limit(sel);
						age_r   <= '0;
					end
				end
				default:
				begin
					age_r <= age_r + 1'b1;
					if (start)
					begin
						cnt_r <= limit(sel);
						lim_r <= limit(sel);
						age_r <= '0;
					end
					else if (done)
						state_r <= BGC_TMR_IDLE;
					else if (cnt_r == 1'b1)
					begin
						expire  <= 1'b1; // see R3
						state_r <= BGC_TMR_IDLE;
					end
					else
						cnt_r <= cnt_r - 1'b1;
				end
			endcase
		end
	end

	assign busy = (state_r == BGC_TMR_RUN);

	retry_exact_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R3
		expire |-> (age_r == lim_r))
		else $error("retry timeout fired at the wrong count");

	retry_done_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R3
		(busy && done && !start) |=> (!busy && !expire))
		else $error("retry timer kept running after completion");

endmodule // bgc_retry_timer

// [design/bgc_regs.sv]
// Purpose: subsystem alias and general control configuration registers
// Assumes: one configuration access per cycle from the bridge core
// Notes:   reset pins are synchronised; every field resets on any reset
// Function
// R1: upper alias half shows as product code
// R2: lower alias half shows as maker code
// R3: retry field selects configuration retry timeout
// R4: bits 29:28 of control read zero
// R5: low-swing bit sets half-amplitude transmit, resets zero
// R6: version bit picks 010b/0 or 011b/1
// R7: strict bit with zero count grants extended VC
// R8: strict bit picks low-priority count default
// R9: force bit makes upstream reads read-multiple
// R10: ASPM default bit picks 00b or 11b
// R11: power response drives override pin, clock stop
// R12: code 100 answers unsupported except exempt ones
// R13: software never writes reserved power codes
// R14: dagger fields reset on any of three resets
// R15: alias reads return latest write next access
`timescale 1ns/10ps
module bgc_regs #(
	parameter int unsigned RETRY_1MS_CYC  = bgc_pkg::BGC_RETRY1_US * bgc_pkg::BGC_CLK_MHZ,
	parameter int unsigned RETRY_25MS_CYC = bgc_pkg::BGC_RETRY2_US * bgc_pkg::BGC_CLK_MHZ,
	parameter int unsigned RETRY_50MS_CYC = bgc_pkg::BGC_RETRY3_US * bgc_pkg::BGC_CLK_MHZ
) (
	input  wire logic        CLK_SYS,
	input  wire logic        RSTN,
	input  wire logic        FUNDAMENTAL_RESET_PIN_N,
	input  wire logic        GLOBAL_RESET_PIN_N,
	input  wire logic        CFG_WR,
	input  wire logic        CFG_RD,
	input  wire logic [7:0]  CFG_ADDR,
	input  wire logic [3:0]  CFG_BE,
	input  wire logic [31:0] CFG_WDATA,
	output logic      [31:0] CFG_RDATA,
	output logic             CFG_ACK,
	output logic             CFG_CLAIM,
	output logic      [15:0] BOARD_PRODUCT_CODE,
	output logic      [15:0] BOARD_MAKER_CODE,
	input  wire logic        CFG_RETRY_START,
	input  wire logic        CFG_RETRY_DONE,
	output logic             CFG_RETRY_EXPIRE,
	output logic             TX_LOW_SWING,
	output logic      [2:0]  PM_REVISION_FIELD,
	output logic             NO_SOFT_RESET,
	input  wire logic [2:0]  LOW_PRIO_COUNT,
	output logic      [2:0]  LOW_PRIO_COUNT_DEFAULT,
	output logic             EXT_VC_STRICT_GRANT,
	output logic             UPSTREAM_READ_MULTIPLE_FORCE,
	output logic      [1:0]  LINK_PM_CONTROL_DEFAULT,
	input  wire logic        SLOT_POWER_SHORT,
	output logic             POWER_OVERRIDE_PIN,
	output logic             SEC_CLOCK_STOP,
	output logic             UR_MODE,
	input  wire logic        TXN_VALID,
	input  wire logic        TXN_EXEMPT,
	output logic             TXN_UR
);
	import bgc_pkg::*;

	logic          fundamental_reset_pin_s1_r;
	logic          fundamental_reset_pin_s2_r;
	logic          global_reset_pin_s1_r;
	logic          global_reset_pin_s2_r;
	logic          fld_rst;
	logic          fld_rst_n;
	logic [31:0]   alias_r;
	logic [31:0]   alias_nxt;
	logic [31:0]   ctrl_r;
	logic [31:0]   ctrl_nxt;
	logic [31:0]   rdata_nxt;
	logic          hit_ro;
	logic          hit_alias;
	logic          hit_ctrl;
	logic          hit_any;
	logic          strict_w;
	logic          pmrev_w;
	logic          aspm_w;
	bgc_pwr_resp_t pwr_code_w;
	logic          pwr_pin_w;
	logic          pwr_clk_w;
	logic          pwr_ur_w;

	// byte-enable merge, used by both writable words
	function automatic logic [31:0] be_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] m;
		m = old_v;
		for (int i = 0; i < 4; i++)
			if (be[i])
				m[i*8 +: 8] = new_v[i*8 +: 8];
		be_merge = m;
	endfunction

	// reset pins are asynchronous to the core, two stages before use
	always_ff @(posedge CLK_SYS)
	begin
		if (!RSTN)
		begin
			fundamental_reset_pin_s1_r <= 1'b0;
			fundamental_reset_pin_s2_r <= 1'b0;
			global_reset_pin_s1_r  <= 1'b0;
			global_reset_pin_s2_r  <= 1'b0;
		end
		else
		begin
			fundamental_reset_pin_s1_r <= FUNDAMENTAL_RESET_PIN_N;
			fundamental_reset_pin_s2_r <= fundamental_reset_pin_s1_r;
			global_reset_pin_s1_r  <= GLOBAL_RESET_PIN_N;
			global_reset_pin_s2_r  <= global_reset_pin_s1_r;
		end
	end

	// any of power-on, fundamental or global reset clears the fields
	assign fld_rst   = !RSTN || !fundamental_reset_pin_s2_r || !global_reset_pin_s2_r; // see R14
	assign fld_rst_n = !fld_rst;

	// address decode, low address bits ignored since every word is aligned
	assign hit_ro    = (CFG_ADDR[7:2] == BGC_OFF_SUBSYS_RO[7:2]);
	assign hit_alias = (CFG_ADDR[7:2] == BGC_OFF_ALIAS[7:2]);
	assign hit_ctrl  = (CFG_ADDR[7:2] == BGC_OFF_CTRL[7:2]);
	assign hit_any   = hit_ro || hit_alias || hit_ctrl;

	// next register values; the read-only words at 84h ignore writes
	assign alias_nxt = fld_rst ? BGC_ALIAS_RST : // see R14
		(CFG_WR && hit_alias) ? be_merge(alias_r, CFG_WDATA, CFG_BE) : alias_r; // see R1 R2
	assign ctrl_nxt  = fld_rst ? BGC_CTRL_RST : // see R14
		(CFG_WR && hit_ctrl) ? (be_merge(ctrl_r, CFG_WDATA, CFG_BE) & BGC_CTRL_WMASK) :
		ctrl_r; // see R4

	// read data: the 84h word is the alias seen from the standard header
	assign rdata_nxt = (hit_ro || hit_alias) ? alias_r : // see R15
		hit_ctrl ? (ctrl_r & BGC_CTRL_WMASK) : BGC_RD_UNMAPPED; // see R4

	// decoded control fields, taken from the next value so outputs track the register
	assign strict_w   = ctrl_nxt[BGC_STRICT_BIT];
	assign pmrev_w    = ctrl_nxt[BGC_PMREV_BIT];
	assign aspm_w     = ctrl_nxt[BGC_ASPM_BIT];
	assign pwr_code_w = bgc_pwr_resp_t'(ctrl_nxt[BGC_PWR_LSB +: 3]);

	// reserved codes fall through to no action rather than a guessed one
	assign pwr_pin_w = SLOT_POWER_SHORT && ((pwr_code_w == BGC_PWR_PIN) ||
		(pwr_code_w == BGC_PWR_BOTH)); // see R11 R13
	assign pwr_clk_w = SLOT_POWER_SHORT && ((pwr_code_w == BGC_PWR_CLKSTOP) ||
		(pwr_code_w == BGC_PWR_BOTH)); // see R11 R13
	assign pwr_ur_w  = SLOT_POWER_SHORT && (pwr_code_w == BGC_PWR_UR); // see R12 R13

	// the two stored words
	always_ff @(posedge CLK_SYS)
	begin
		alias_r <= alias_nxt;
		ctrl_r  <= ctrl_nxt;
	end

	// configuration answer, one cycle after the access
	always_ff @(posedge CLK_SYS)
	begin
		if (fld_rst)
		begin
			CFG_ACK   <= 1'b0;
			CFG_CLAIM <= 1'b0;
			CFG_RDATA <= BGC_RD_UNMAPPED;
		end
		else
		begin
			CFG_ACK   <= CFG_RD || CFG_WR;
			CFG_CLAIM <= (CFG_RD || CFG_WR) && hit_any;
			CFG_RDATA <= CFG_RD ? rdata_nxt : BGC_RD_UNMAPPED;
		end
	end

	// field outputs; loading from the next values keeps them in step with reset
	always_ff @(posedge CLK_SYS)
	begin
		BOARD_PRODUCT_CODE           <= alias_nxt[BGC_PRODUCT_LSB +: 16]; // see R1
		BOARD_MAKER_CODE             <= alias_nxt[15:0]; // see R2
		TX_LOW_SWING                 <= ctrl_nxt[BGC_LOWSWING_BIT]; // see R5
		PM_REVISION_FIELD            <= pmrev_w ? BGC_PMREV_V12 : BGC_PMREV_V11; // see R6
		NO_SOFT_RESET                <= pmrev_w; // see R6
		LOW_PRIO_COUNT_DEFAULT       <= strict_w ? BGC_LPC_STRICT : BGC_LPC_DEF_CLR; // see R8
		UPSTREAM_READ_MULTIPLE_FORCE <= ctrl_nxt[BGC_RDMULT_BIT]; // see R9
		LINK_PM_CONTROL_DEFAULT      <= aspm_w ? BGC_ASPM_L0S_L1 : BGC_ASPM_OFF; // see R10
	end

	// arbitration and power actions; a short never reaches outputs during reset
	always_ff @(posedge CLK_SYS)
	begin
		if (fld_rst)
		begin
			EXT_VC_STRICT_GRANT <= 1'b0;
			POWER_OVERRIDE_PIN  <= 1'b0;
			SEC_CLOCK_STOP      <= 1'b0;
			UR_MODE             <= 1'b0;
			TXN_UR              <= 1'b0;
		end
		else
		begin
			EXT_VC_STRICT_GRANT <= strict_w && (LOW_PRIO_COUNT == BGC_LPC_STRICT); // see R7
			POWER_OVERRIDE_PIN  <= pwr_pin_w; // see R11
			SEC_CLOCK_STOP      <= pwr_clk_w; // see R11
			UR_MODE             <= pwr_ur_w; // see R12
			TXN_UR              <= UR_MODE && TXN_VALID && !TXN_EXEMPT; // see R12
		end
	end

	// retry timeout, selected by the live control field
	bgc_retry_timer #(
		.C1 (RETRY_1MS_CYC),
		.C2 (RETRY_25MS_CYC),
		.C3 (RETRY_50MS_CYC)
	) u_retry (
		.clk_sys (CLK_SYS),
		.rst_n   (fld_rst_n),
		.start   (CFG_RETRY_START),
		.done    (CFG_RETRY_DONE),
		.sel     (ctrl_r[BGC_RETRY_LSB +: 2]), // see R3
		.expire  (CFG_RETRY_EXPIRE),
		.busy    ()
	);

	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (fld_rst);

	sequence s_wr_alias_hi;
		CFG_WR && hit_alias && CFG_BE[3] && CFG_BE[2];
	endsequence

	sequence s_wr_alias_lo;
		CFG_WR && hit_alias && CFG_BE[1] && CFG_BE[0];
	endsequence

	sequence s_rd_ro;
		CFG_RD && hit_ro && !CFG_WR;
	endsequence

	alias_product_a: assert property ( // see R1
		s_wr_alias_hi |=> (BOARD_PRODUCT_CODE == $past(CFG_WDATA[31:16])))
		else $error("product code does not follow alias write");

	alias_maker_a: assert property ( // see R2
		s_wr_alias_lo |=> (BOARD_MAKER_CODE == $past(CFG_WDATA[15:0])))
		else $error("maker code does not follow alias write");

	alias_readback_a: assert property ( // see R15
		s_wr_alias_hi ##1 !(CFG_WR && hit_alias) ##1 s_rd_ro |=>
		(CFG_RDATA[31:16] == $past(CFG_WDATA[31:16], 3)) && CFG_ACK && CFG_CLAIM)
		else $error("alias read misses the latest write");

	rsvd_zero_a: assert property ( // see R4
		(CFG_RD && hit_ctrl) |=> (CFG_RDATA[BGC_RSVD_LSB +: 2] == 2'h0))
		else $error("reserved control bits read nonzero");

	swing_readback_a: assert property ( // see R5
		(CFG_RD && hit_ctrl && !CFG_WR) |=> (CFG_RDATA[BGC_LOWSWING_BIT] == TX_LOW_SWING))
		else $error("low swing output differs from register");

	pm_pairing_a: assert property ( // see R6
		PM_REVISION_FIELD == (NO_SOFT_RESET ? BGC_PMREV_V12 : BGC_PMREV_V11))
		else $error("power management version and soft reset flag disagree");

	vc_strict_a: assert property ( // see R7
		!fld_rst |=> (EXT_VC_STRICT_GRANT ==
		($past(strict_w) && ($past(LOW_PRIO_COUNT) == BGC_LPC_STRICT))))
		else $error("extended VC strict grant wrong");

	lpc_default_a: assert property ( // see R8
		(LOW_PRIO_COUNT_DEFAULT == BGC_LPC_STRICT) == ctrl_r[BGC_STRICT_BIT])
		else $error("low priority count default wrong");

	rdmult_track_a: assert property ( // see R9
		UPSTREAM_READ_MULTIPLE_FORCE == ctrl_r[BGC_RDMULT_BIT])
		else $error("read multiple force differs from register");

	aspm_default_a: assert property ( // see R10
		LINK_PM_CONTROL_DEFAULT == (ctrl_r[BGC_ASPM_BIT] ? BGC_ASPM_L0S_L1 : BGC_ASPM_OFF))
		else $error("link power default wrong");

	pwr_pin_a: assert property ( // see R11
		(SLOT_POWER_SHORT && (pwr_code_w == BGC_PWR_BOTH)) [*2] |=>
		(POWER_OVERRIDE_PIN && SEC_CLOCK_STOP && !UR_MODE))
		else $error("power response both not applied");

	ur_answer_a: assert property ( // see R12
		(UR_MODE && TXN_VALID) |=> (TXN_UR == !$past(TXN_EXEMPT)))
		else $error("unsupported request answer wrong");

	pin_reset_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // see R14
		(!FUNDAMENTAL_RESET_PIN_N) [*3] |=>
		(ctrl_r == BGC_CTRL_RST) && (alias_r == BGC_ALIAS_RST) && !TX_LOW_SWING)
		else $error("fundamental reset did not restore defaults");

	// the header word never takes a write, and every access gets its answer
	ro_write_a: assert property ( // see R15
		(CFG_WR && hit_ro) |=> (alias_r == $past(alias_r)))
		else $error("read only subsystem word took a write");

	ack_claim_a: assert property ( // see R15
		(CFG_RD || CFG_WR) |=> (CFG_ACK && (CFG_CLAIM == $past(hit_any))))
		else $error("configuration access not answered");

	ur_mode_a: assert property ( // see R12
		(SLOT_POWER_SHORT && (pwr_code_w == BGC_PWR_UR)) |=>
		(UR_MODE && !POWER_OVERRIDE_PIN && !SEC_CLOCK_STOP))
		else $error("unsupported request mode not applied");

	global_reset_pin_reset_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // see R14
		(!GLOBAL_RESET_PIN_N) [*3] |=>
		(ctrl_r == BGC_CTRL_RST) && (alias_r == BGC_ALIAS_RST) && !UR_MODE)
		else $error("global reset did not restore defaults");

endmodule // bgc_regs

// [tb/tb.sv]
// Purpose: self-checking bench of the bridge general control registers
// Assumes: all inputs change on the falling clock edge
// Notes:   long retry counts shortened by parameter, the 25 us count is kept
`timescale 1ns/10ps
module tb;
	import bgc_pkg::*;
	localparam int unsigned C1 = 20;
	localparam int unsigned C2 = 40;
	localparam int unsigned C3 = 60;
	logic        clk_sys = 1'b0;
	logic        rstn = 1'b0;
	logic        frst_n = 1'b1;
	logic        global_reset_pin_n = 1'b1;
	logic        cfg_wr = 1'b0;
	logic        cfg_rd = 1'b0;
	logic [7:0]  cfg_addr = 8'h00;
	logic [3:0]  cfg_be = 4'h0;
	logic [31:0] cfg_wdata = 32'h0;
	logic        rt_start = 1'b0, rt_done = 1'b0, short_lim = 1'b0;
	logic        txn_valid = 1'b0, txn_exempt = 1'b0;
	logic [2:0]  lp_count = 3'h0;
	wire  [31:0] cfg_rdata;
	wire  [15:0] product, maker;
	wire         cfg_ack, cfg_claim, rt_expire, low_swing, no_soft, strict_grant;
	wire         rd_mult, pwr_pin, clk_stop, ur_mode, txn_ur;
	wire  [2:0]  pm_rev, lpc_def;
	wire  [1:0]  aspm_def;
	int          err_count = 0, num_checks = 0, seed = 48, cnt;
	int          rt_n[4] = '{BGC_RETRY0_CYC, C1, C2, C3};
	logic [32:0] exp_q[$];
	logic [31:0] alias_v, ctrl_v, v;

	bgc_regs #(.RETRY_1MS_CYC(C1), .RETRY_25MS_CYC(C2), .RETRY_50MS_CYC(C3)) dut (
		.CLK_SYS(clk_sys), .RSTN(rstn), .FUNDAMENTAL_RESET_PIN_N(frst_n),
		.GLOBAL_RESET_PIN_N(global_reset_pin_n), .CFG_WR(cfg_wr), .CFG_RD(cfg_rd),
		.CFG_ADDR(cfg_addr), .CFG_BE(cfg_be), .CFG_WDATA(cfg_wdata),
		.CFG_RDATA(cfg_rdata), .CFG_ACK(cfg_ack), .CFG_CLAIM(cfg_claim),
		.BOARD_PRODUCT_CODE(product), .BOARD_MAKER_CODE(maker),
		.CFG_RETRY_START(rt_start), .CFG_RETRY_DONE(rt_done),
		.CFG_RETRY_EXPIRE(rt_expire), .TX_LOW_SWING(low_swing),
		.PM_REVISION_FIELD(pm_rev), .NO_SOFT_RESET(no_soft),
		.LOW_PRIO_COUNT(lp_count), .LOW_PRIO_COUNT_DEFAULT(lpc_def),
		.EXT_VC_STRICT_GRANT(strict_grant), .UPSTREAM_READ_MULTIPLE_FORCE(rd_mult),
		.LINK_PM_CONTROL_DEFAULT(aspm_def), .SLOT_POWER_SHORT(short_lim),
		.POWER_OVERRIDE_PIN(pwr_pin), .SEC_CLOCK_STOP(clk_stop), .UR_MODE(ur_mode),
		.TXN_VALID(txn_valid), .TXN_EXEMPT(txn_exempt), .TXN_UR(txn_ur)
	);

	// free-running system clock, 8 ns period
	always #4 clk_sys = ~clk_sys;

	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one config access; expected {claim, rdata} noted before the request
	task automatic cfg(input logic wr, input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] d, input logic [32:0] e);
		exp_q.push_back(e);
		@(negedge clk_sys);
		cfg_wr = wr;
		cfg_rd = ~wr;
		cfg_addr = a;
		cfg_be = be;
		cfg_wdata = d;
		@(negedge clk_sys);
		cfg_wr = 1'b0;
		cfg_rd = 1'b0;
	endtask

	// answers are looked at in the one cycle they stand
	always @(negedge clk_sys)
		if (cfg_ack === 1'b1)
		begin
			if (exp_q.size() == 0)
				chk({cfg_claim, cfg_rdata}, 33'h1ffffffff);
			else
				chk({cfg_claim, cfg_rdata}, exp_q.pop_front());
		end

	// field outputs expected from a control word
	function automatic logic [10:0] fexp(input logic [31:0] c);
		return {c[27], c[26] ? BGC_PMREV_V12 : BGC_PMREV_V11, c[26],
			c[25] ? BGC_LPC_STRICT : BGC_LPC_DEF_CLR, c[24],
			c[23] ? BGC_ASPM_L0S_L1 : BGC_ASPM_OFF};
	endfunction

	task automatic txn(input logic ex, input logic e);
		@(negedge clk_sys);
		txn_valid = 1'b1;
		txn_exempt = ex;
		@(negedge clk_sys);
		txn_valid = 1'b0;
		chk(txn_ur, e);
	endtask

	// count cycles from the start edge to the expiry pulse
	task automatic run_retry(input int n);
		cnt = 0;
		@(negedge clk_sys);
		rt_start = 1'b1;
		@(negedge clk_sys);
		rt_start = 1'b0;
		while (rt_expire !== 1'b1 && cnt < 4000)
		begin
			@(negedge clk_sys);
			cnt++;
		end
		chk(cnt, n);
		@(negedge clk_sys);
		chk(rt_expire, 1'b0);
	endtask

	task automatic conclude();
		chk(exp_q.size(), 0);
		$display("checks=%0d errors=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// watchdog, well beyond the expected run of under 10000 cycles
	initial
	begin
		#(20000 * 8);
		err_count++;
		conclude();
	end

	// main sequence
	initial
	begin
		repeat (4) @(negedge clk_sys);
		rstn = 1'b1;
		repeat (4) @(negedge clk_sys);
		cfg(1'b0, BGC_OFF_CTRL, 4'hf, 32'h0, {1'b1, BGC_CTRL_RST});
		cfg(1'b0, BGC_OFF_ALIAS, 4'hf, 32'h0, {1'b1, BGC_ALIAS_RST});
		chk({low_swing, pm_rev, no_soft, lpc_def, rd_mult, aspm_def}, fexp(BGC_CTRL_RST));
		run_retry(C2);
		// alias writes, partial lanes, read-only place, unmapped place
		alias_v = $random(seed);
		cfg(1'b1, BGC_OFF_ALIAS, 4'hf, alias_v, {1'b1, 32'h0});
		cfg(1'b0, BGC_OFF_SUBSYS_RO, 4'hf, 32'h0, {1'b1, alias_v});
		chk({product, maker}, alias_v);
		v = $random(seed);
		cfg(1'b1, BGC_OFF_ALIAS, 4'h3, v, {1'b1, 32'h0});
		alias_v[15:0] = v[15:0];
		cfg(1'b1, BGC_OFF_SUBSYS_RO, 4'hf, ~v, {1'b1, 32'h0});
		cfg(1'b0, BGC_OFF_ALIAS, 4'hf, 32'h0, {1'b1, alias_v});
		cfg(1'b0, BGC_OFF_SUBSYS_RO, 4'hf, 32'h0, {1'b1, alias_v});
		chk({product, maker}, alias_v);
		cfg(1'b0, 8'h40, 4'hf, 32'h0, {1'b0, BGC_RD_UNMAPPED});
		// control word fields, extremes then random
		for (int i = 0; i < 6; i++)
		begin
			ctrl_v = (i < 2) ? {32{i[0]}} : $random(seed);
			ctrl_v[22] = 1'b0;
			if (i == 2)
				ctrl_v[25] = 1'b1;
			cfg(1'b1, BGC_OFF_CTRL, 4'hf, ctrl_v, {1'b1, 32'h0});
			ctrl_v[29:28] = 2'b00;
			cfg(1'b0, BGC_OFF_CTRL, 4'hf, 32'h0, {1'b1, ctrl_v});
			lp_count = 3'($random(seed)) & {3{i[0]}};
			repeat (2) @(negedge clk_sys);
			chk({low_swing, pm_rev, no_soft, lpc_def, rd_mult, aspm_def}, fexp(ctrl_v));
			chk(strict_grant, ctrl_v[25] && lp_count == 3'h0);
		end
		// slot power responses, reserved codes never written
		for (int c = 0; c < 5; c++)
		begin
			ctrl_v[22:20] = 3'(c);
			cfg(1'b1, BGC_OFF_CTRL, 4'hf, ctrl_v, {1'b1, 32'h0});
			for (int s = 0; s < 2; s++)
			begin
				short_lim = s[0];
				repeat (2) @(negedge clk_sys);
				chk({pwr_pin, clk_stop, ur_mode},
					{3{s[0]}} & {c == 1 || c == 3, c == 2 || c == 3, c == 4});
				txn(1'b0, s[0] && c == 4);
				txn(1'b1, 1'b0);
			end
			short_lim = 1'b0;
		end
		// every retry time, then a cancel by done
		for (int s = 0; s < 4; s++)
		begin
			ctrl_v[31:30] = 2'(s);
			cfg(1'b1, BGC_OFF_CTRL, 4'hf, ctrl_v, {1'b1, 32'h0});
			run_retry(rt_n[s]);
		end
		@(negedge clk_sys);
		rt_start = 1'b1;
		@(negedge clk_sys);
		rt_start = 1'b0;
		repeat (5) @(negedge clk_sys);
		rt_done = 1'b1;
		@(negedge clk_sys);
		rt_done = 1'b0;
		cnt = 0;
		repeat (C3 + 10)
		begin
			@(negedge clk_sys);
			cnt += int'(rt_expire);
		end
		chk(cnt, 0);
		// each reset pin restores all fields
		for (int p = 0; p < 2; p++)
		begin
			cfg(1'b1, BGC_OFF_ALIAS, 4'hf, ~alias_v, {1'b1, 32'h0});
			@(negedge clk_sys);
			frst_n = p[0];
			global_reset_pin_n = ~p[0];
			repeat (4) @(negedge clk_sys);
			frst_n = 1'b1;
			global_reset_pin_n = 1'b1;
			repeat (4) @(negedge clk_sys);
			cfg(1'b0, BGC_OFF_CTRL, 4'hf, 32'h0, {1'b1, BGC_CTRL_RST});
			cfg(1'b0, BGC_OFF_ALIAS, 4'hf, 32'h0, {1'b1, BGC_ALIAS_RST});
		end
		repeat (3) @(negedge clk_sys);
		conclude();
	end
endmodule // tb
